// [verilog/vaca_arbiter.sv]
// Command decode and priority arbitration for a valve actuator
// Assumes cyclic writes arrive as one-cycle strobes with data
`timescale 1ns/100ps
`default_nettype none

module vaca_arbiter
    import vaca_pkg::*;
(
    input  wire logic                       sys_clk,      // 100 MHz clock
    input  wire logic                       rst,          // Async reset
    input  wire logic                       cmdWrite,     // Command word strobe
    input  wire logic [vaca_pkg::CMD_W-1:0] actuatorCommandWord, // Command
    input  wire logic                       posWrite,     // Demand word strobe
    input  wire logic [vaca_pkg::POS_W-1:0] positionDemandWord, // Demand
    input  wire logic                       relayWrite,   // Relay strobe
    input  wire logic [vaca_pkg::RELAY_N-1:0] relayCmd,   // Relay bits
    input  wire vaca_pkg::vaca_hw_s         hwIn,         // Hard-wired inputs
    input  wire logic                       hwEnable,     // Auxiliary mask
    input  wire logic                       selRemote,    // Selector remote
    input  wire logic                       selLocalStop, // Selector local stop
    input  wire logic                       cfgEsdDisable, // Esd input disables
    input  wire logic                       cfgEsdOverStop, // Esd over stop
    input  wire logic                       cfgLimitRange, // Limited range
    input  wire logic                       cfgPstFromOpen, // Stroke start end
    input  wire logic                       atOpen,       // Open limit
    input  wire logic                       atClosed,     // Closed limit
    input  wire logic                       pstDone,      // Stroke finished
    output logic                            contention,   // Contention flag
    output vaca_pkg::vaca_drive_s           drive,        // Drive request
    output logic [vaca_pkg::RELAY_N-1:0]    relayOut,     // Relay coils
    output logic                            netDisabled   // Network disabled
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Count set defined bits
    function automatic logic [2:0] bitCount(input logic [CMD_DEF_W-1:0] v);
        logic [2:0] n;
        n = 3'b000;
        for (int i = 0; i < CMD_DEF_W; i++) begin
            n = n + {2'b00, v[i]};
        end
        return n;
    endfunction

    logic [CMD_DEF_W-1:0] defBits;
    logic [2:0]           nBits;
    logic                 cmdOne;
    logic                 cmdMulti;
    assign defBits  = actuatorCommandWord[CMD_DEF_W-1:0];
    assign nBits    = bitCount(defBits);
    assign cmdOne   = cmdWrite && (nBits == 3'b001);
    assign cmdMulti = cmdWrite && (nBits > 3'b001);

    logic hwEsdAct;
    logic netBlock;
    assign hwEsdAct = hwEnable && hwIn.emergency_shutdown && !cfgEsdDisable;
    assign netBlock = hwIn.emergency_shutdown && cfgEsdDisable;

    // ------------------------------------------------------------
    // Network command latch
    // ------------------------------------------------------------
    vaca_act_e   netAct_q;
    vaca_act_e   netAct_d;
    logic        netEsd_q;
    logic [15:0] demand_q;
    logic        hwLatch_q;   // Maintained hard-wired in force
    logic        stopPrev_q;
    vaca_act_e   hwAct_q;
    logic        netNew;
    logic        netStop;

    assign netNew  = cmdOne && !netBlock;
    assign netStop = netNew && defBits[CMD_STOP_BIT];

    // Hard-wired stop edge and open/close command levels
    logic stopEdge;
    logic hwOpenCmd;
    logic hwCloseCmd;
    assign stopEdge   = hwEnable && stopPrev_q && !hwIn.stopClosed;
    assign hwOpenCmd  = hwEnable && hwIn.open;
    assign hwCloseCmd = hwEnable && hwIn.close;

    // start end judged when the command arrives
    logic pstOk;
    assign pstOk = cfgPstFromOpen ? atOpen : atClosed;

    always_comb begin
        netAct_d = netAct_q;
        if (netNew) begin
            unique case (1'b1)
                defBits[CMD_CLOSE_BIT]: netAct_d = ACT_CLOSE;
                defBits[CMD_OPEN_BIT]:  netAct_d = ACT_OPEN;
                defBits[CMD_ESD_BIT]:   netAct_d = ACT_ESD;
                defBits[CMD_POS_BIT]:   netAct_d = ACT_POS;
                defBits[CMD_PST_BIT]:   netAct_d = pstOk ? ACT_PST : ACT_IDLE;
                default:                netAct_d = ACT_IDLE;
            endcase
        // stop edge, or pstDone during a partial stroke, ends the network action
        end else if (stopEdge || (netAct_q == ACT_PST && pstDone)) begin
            netAct_d = ACT_IDLE;
        end
    end

    // Network and hard-wired state registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            netAct_q   <= ACT_IDLE;
            netEsd_q   <= 1'b0;
            demand_q   <= POS_MIN;
            hwLatch_q  <= 1'b0;
            stopPrev_q <= 1'b0;
            hwAct_q    <= ACT_IDLE;
        end else begin
            netAct_q   <= netAct_d;
            stopPrev_q <= hwIn.stopClosed;
            if (netNew) begin
                netEsd_q <= defBits[CMD_ESD_BIT];
            end
            if (posWrite) begin
                demand_q <= (positionDemandWord > POS_MAX) ?
                            POS_MAX : positionDemandWord;
            end
            // later network command ends maintained one
            if (hwOpenCmd || hwCloseCmd) begin
                hwLatch_q <= 1'b1;
                hwAct_q   <= hwOpenCmd ? ACT_OPEN : ACT_CLOSE;
            end else if (netNew || stopEdge) begin
                hwLatch_q <= 1'b0;
                hwAct_q   <= ACT_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    logic      standing;
    logic      maintained;
    logic      esdAllowed;
    logic      remoteOk;
    vaca_act_e netEff;
    vaca_act_e hwEff;
    vaca_act_e arb;
    logic [15:0] tgt;

    assign remoteOk   = selRemote && !netBlock;
    // emergency in local, stop by config
    assign esdAllowed = !selLocalStop || cfgEsdOverStop;
    assign standing   = (hwOpenCmd || hwCloseCmd) && !hwIn.maintain;
    assign maintained = hwLatch_q && hwIn.maintain;
    assign hwEff      = hwOpenCmd ? ACT_OPEN :
                        hwCloseCmd ? ACT_CLOSE : hwAct_q;

    logic posClose;
    logic posOpen;
    assign posClose = (demand_q == POS_MIN);
    assign posOpen  = (demand_q == POS_MAX);

    always_comb begin
        netEff = netAct_q;
        tgt    = demand_q;
        if (netAct_q == ACT_POS) begin
            if (!cfgLimitRange && posClose) begin
                netEff = ACT_CLOSE;
            end else if (!cfgLimitRange && posOpen) begin
                netEff = ACT_OPEN;
            end else if (cfgLimitRange &&
                         ((posClose && atClosed) ||
                          (posOpen && atOpen))) begin
                netEff = ACT_IDLE;
            end
        end
    end

    always_comb begin
        if ((netEsd_q && !netBlock) || hwEsdAct) begin
            arb = esdAllowed ? ACT_ESD : ACT_IDLE;
        end else if (!remoteOk && !selRemote) begin
            arb = ACT_IDLE;
        end else if (standing || (maintained && !netNew)) begin
            arb = hwEff;
        end else if (!selRemote) begin
            arb = ACT_IDLE;
        end else begin
            arb = netEff;
        end
    end

    // ------------------------------------------------------------
    // Outputs and relays
    // ------------------------------------------------------------
    // relays cleared on power return
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            relayOut    <= '0;
            contention  <= 1'b0;
            drive       <= '{act: ACT_IDLE, target: POS_MIN};
            netDisabled <= 1'b0;
        end else begin
            if (relayWrite) begin
                relayOut <= relayCmd;
            end
            // contention flag, cleared by good write
            if (cmdMulti) begin
                contention <= 1'b1;
            end else if (cmdOne) begin
                contention <= 1'b0;
            end
            if (stopEdge && arb != ACT_ESD) begin
                drive <= '{act: ACT_IDLE, target: tgt};
            end else begin
                drive <= '{act: arb, target: tgt};
            end
            netDisabled <= netBlock;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // discarded write
    chk_multi_discard: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cmdMulti && !stopEdge && !pstDone) |=>
            netAct_q == $past(netAct_q))
        else $error("multi-bit command changed action");
    chk_contention_flag: assert property (
        @(posedge sys_clk) disable iff (rst)
        cmdMulti |=> contention)
        else $error("contention not flagged");
    chk_esd_latch: assert property (
        @(posedge sys_clk) disable iff (rst)
        (netNew && defBits[CMD_ESD_BIT]) |=> netEsd_q)
        else $error("network emergency not latched");
    chk_esd_release: assert property (
        @(posedge sys_clk) disable iff (rst)
        netStop |=> !netEsd_q)
        else $error("stop did not release emergency");
    chk_esd_priority: assert property (
        @(posedge sys_clk) disable iff (rst)
        (hwEsdAct && !selLocalStop && !stopEdge) |=> drive.act == ACT_ESD)
        else $error("emergency not driven");
    chk_local_idle: assert property (
        @(posedge sys_clk) disable iff (rst)
        (!selRemote && !netEsd_q && !hwEsdAct) |=> drive.act == ACT_IDLE)
        else $error("moved while not remote");
    chk_zero_close: assert property (
        @(posedge sys_clk) disable iff (rst)
        (arb == ACT_POS) |-> !(posClose && !cfgLimitRange))
        else $error("zero demand not closed");
    chk_relay_reset: assert property (
        @(posedge sys_clk)
        $rose(!rst) |-> relayOut == '0)
        else $error("relays not cleared after reset");
    chk_stop_edge: assert property (
        @(posedge sys_clk) disable iff (rst)
        (stopEdge && arb != ACT_ESD) |=> drive.act == ACT_IDLE)
        else $error("stop edge ignored");
    chk_pst_start: assert property (
        @(posedge sys_clk) disable iff (rst)
        (netNew && defBits[CMD_PST_BIT] && !pstOk) |=> netAct_q == ACT_IDLE)
        else $error("stroke started off end");

    cov_esd:  cover property (@(posedge sys_clk) drive.act == ACT_ESD);
    cov_pos:  cover property (@(posedge sys_clk) drive.act == ACT_POS);
    cov_cont: cover property (@(posedge sys_clk) cmdMulti);
    cov_pst:  cover property (@(posedge sys_clk) drive.act == ACT_PST);

endmodule

`default_nettype wire

// [verilog/vaca_pkg.sv]
// Package for the valve actuator command arbiter
// Assumes a single 100 MHz clock domain and synchronous inputs
package vaca_pkg;

    // ------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------
    localparam int CMD_W         = 16;
    localparam int CMD_STOP_BIT  = 0;
    localparam int CMD_CLOSE_BIT = 1;
    localparam int CMD_OPEN_BIT  = 2;
    localparam int CMD_ESD_BIT   = 3;
    localparam int CMD_POS_BIT   = 4;
    localparam int CMD_PST_BIT   = 5;
    localparam int CMD_DEF_W     = 6;

    // ------------------------------------------------------------
    // Position demand and relays
    // ------------------------------------------------------------
    localparam int          POS_W     = 16;
    localparam logic [15:0] POS_MIN   = 16'h0000;
    localparam logic [15:0] POS_MAX   = 16'h03E8;
    localparam int          RELAY_N   = 4;

    // Motion the arbiter asks of the motor drive
    typedef enum logic [2:0] {
        ACT_IDLE  = 3'b000,
        ACT_CLOSE = 3'b001,
        ACT_OPEN  = 3'b010,
        ACT_ESD   = 3'b011,
        ACT_POS   = 3'b100,
        ACT_PST   = 3'b101
    } vaca_act_e;

    // Hard-wired inputs grouped
    typedef struct packed {
        logic open;
        logic close;
        logic stopClosed;   // High while stop contact is closed
        logic emergency_shutdown;
        logic maintain;     // High when command is maintained style
    } vaca_hw_s;

    // Decoded action driven out
    typedef struct packed {
        vaca_act_e   act;
        logic [15:0] target;
    } vaca_drive_s;

endpackage

// [dv/vaca_master.sv]
// Fieldbus master model writing the cyclic output registers
// Assumes the arbiter takes each strobe on the rising edge of sys_clk
`timescale 1ns/100ps
`default_nettype none

module vaca_master
    import vaca_pkg::*;
(
    input  wire logic                   sys_clk,    // Card clock
    output logic                        cmdWrite,   // Command strobe
    output logic [vaca_pkg::CMD_W-1:0]  cmdWord,    // Command word
    output logic                        posWrite,   // Demand strobe
    output logic [vaca_pkg::POS_W-1:0]  posWord,    // Demand word
    output logic                        relayWrite, // Relay strobe
    output logic [vaca_pkg::RELAY_N-1:0] relayBits  // Relay bits
);
    // Quiet bus at time zero
    initial begin
        {cmdWrite, posWrite, relayWrite} = 3'b000;
        {cmdWord, posWord, relayBits} = '0;
    end

    // -----------------------------------------------------------------
    // Register write: 0 command, 1 demand, 2 relays
    // -----------------------------------------------------------------
    // one word per write, bus inverted once released
    task automatic put(input int sel, input logic [15:0] w);
        @(posedge sys_clk);
        cmdWrite   <= (sel == 0);
        posWrite   <= (sel == 1);
        relayWrite <= (sel == 2);
        cmdWord    <= w;
        posWord    <= w;
        relayBits  <= w[3:0];
        @(posedge sys_clk);
        {cmdWrite, posWrite, relayWrite} <= 3'b000;
        cmdWord    <= ~w;
        posWord    <= ~w;
        relayBits  <= ~w[3:0];
    endtask
endmodule

`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the valve actuator command arbiter
// Assumes a master model for writes and bench-driven hard-wired inputs
`timescale 1ns/100ps
`default_nettype none

module tb;
    import vaca_pkg::*;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cmdWrite, posWrite, relayWrite;
    logic [15:0] cmdWord, posWord;
    logic [3:0] relayBits, relayOut, nib;
    vaca_hw_s hwIn = '{stopClosed: 1'b1, default: 1'b0};
    logic selRemote = 1'b0;
    logic selLocalStop = 1'b0;
    logic cfgEsdOverStop = 1'b0;
    logic cfgPstFromOpen = 1'b0;
    logic pstDone = 1'b0;
    logic hwEnable = 1'b1;
    logic cfgEsdDisable = 1'b0;
    logic cfgLimitRange = 1'b0;
    logic atOpen = 1'b0;
    logic atClosed = 1'b0;
    logic contention, netDisabled;
    vaca_drive_s drive;
    int errTotal = 0;
    int testsRun = 0;
    int cycles = 0;
    int seed = 32'h8a70_928d;
    logic [15:0] d;
    vaca_act_e ea;
    logic [15:0] corner [4] = '{16'h0000, 16'h03E8, 16'h04B0, 16'h0000};
    vaca_act_e bitAct [6] = '{ACT_IDLE, ACT_CLOSE, ACT_OPEN, ACT_ESD,
                              ACT_POS, ACT_PST};

    // -----------------------------------------------------------------
    // Clock, timeout and instances
    // -----------------------------------------------------------------
    initial forever #5 sys_clk = ~sys_clk;

    // Cycle ceiling well above the expected run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            finishTest();
        end
    end

    vaca_master vaca_master_inst (.sys_clk(sys_clk), .cmdWrite(cmdWrite),
        .cmdWord(cmdWord), .posWrite(posWrite), .posWord(posWord),
        .relayWrite(relayWrite), .relayBits(relayBits));

    vaca_arbiter vaca_arbiter_inst (.sys_clk(sys_clk), .rst(rst),
        .cmdWrite(cmdWrite), .actuatorCommandWord(cmdWord),
        .posWrite(posWrite), .positionDemandWord(posWord),
        .relayWrite(relayWrite), .relayCmd(relayBits), .hwIn(hwIn),
        .hwEnable(hwEnable), .selRemote(selRemote),
        .selLocalStop(selLocalStop),
        .cfgEsdDisable(cfgEsdDisable), .cfgEsdOverStop(cfgEsdOverStop),
        .cfgLimitRange(cfgLimitRange), .cfgPstFromOpen(cfgPstFromOpen),
        .atOpen(atOpen), .atClosed(atClosed), .pstDone(pstDone),
        .contention(contention), .drive(drive), .relayOut(relayOut),
        .netDisabled(netDisabled));

    // -----------------------------------------------------------------
    // Helpers and expectations
    // -----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input int s, input logic [15:0] w);
        vaca_master_inst.put(s, w);
        tick(1);
    endtask

    task automatic checkAct(input string n, input vaca_act_e e);
        testsRun++;
        if (drive.act !== e) begin
            errTotal++;
            $display("wrong value %s exp %0d seen %0d", n, e, drive.act);
        end
    endtask

    task automatic checkVec(input string n, input logic [15:0] s,
                            input logic [15:0] e);
        testsRun++;
        if (s !== e) begin
            errTotal++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask

    // Action expected from a demand with its end-point cases
    function automatic vaca_act_e posAct(logic [15:0] v, logic lim,
                                         logic c, logic o);
        if (v == POS_MIN) return lim ? (c ? ACT_IDLE : ACT_POS) : ACT_CLOSE;
        if (v >= POS_MAX) return lim ? (o ? ACT_IDLE : ACT_POS) : ACT_OPEN;
        return ACT_POS;
    endfunction

    task automatic finishTest();
        if (errTotal == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        checkAct("reset act", ACT_IDLE);
        checkVec("reset relays", {12'h000, relayOut}, 16'h0000);
        @(posedge sys_clk) selRemote <= 1'b1;
        atClosed <= 1'b1;
        wr(1, 16'h01F4);
        for (int i = 0; i < 6; i++) begin
            wr(0, 16'h0001 << i);
            checkAct("single bit", bitAct[i]);
        end
        wr(0, 16'h0006);
        checkAct("multi bit", ACT_PST);
        checkVec("contention", {15'h0, contention}, 16'h0001);
        wr(0, 16'h0040);
        checkAct("no bit", ACT_PST);
        wr(0, 16'h0002);
        checkVec("contention clr", {15'h0, contention}, 16'h0000);
        @(posedge sys_clk) atClosed <= 1'b0;
        wr(0, 16'h0020);
        checkVec("pst off end", {15'h0, drive.act == ACT_PST}, 16'h0);
        for (int i = 0; i < 10; i++) begin
            d = (i < 4) ? corner[i] : 16'($unsigned($random(seed)) % 1100);
            @(posedge sys_clk) cfgLimitRange <= i[0];
            atClosed <= (d == 16'h0000);
            atOpen <= (d >= POS_MAX);
            wr(1, d);
            wr(0, 16'h0010);
            ea = posAct(d, i[0], d == 16'h0000, d >= POS_MAX);
            checkAct("position act", ea);
            if (ea == ACT_POS)
                checkVec("target", drive.target, d);
        end
        wr(0, 16'h0004);
        checkAct("digital over pos", ACT_OPEN);
        for (int i = 0; i < 3; i++) begin
            nib = 4'($random(seed));
            wr(2, {12'h000, nib});
            checkVec("relays", {12'h000, relayOut}, {12'h000, nib});
        end
        wr(0, 16'h0001);
        @(posedge sys_clk) selRemote <= 1'b0;
        wr(0, 16'h0004);
        checkAct("local open", ACT_IDLE);
        wr(0, 16'h0008);
        checkAct("local esd", ACT_ESD);
        wr(0, 16'h0001);
        checkAct("local stop", ACT_IDLE);
        @(posedge sys_clk) selRemote <= 1'b1;
        hwIn.open <= 1'b1;
        tick(3);
        checkAct("hw open", ACT_OPEN);
        wr(0, 16'h0002);
        checkAct("standing hw", ACT_OPEN);
        @(posedge sys_clk) hwIn.open <= 1'b0;
        hwIn.emergency_shutdown <= 1'b1;
        tick(3);
        checkAct("hw esd", ACT_ESD);
        @(posedge sys_clk) hwIn.emergency_shutdown <= 1'b0;
        tick(3);
        checkAct("esd no latch", ACT_CLOSE);
        wr(0, 16'h0004);
        @(posedge sys_clk) hwIn.stopClosed <= 1'b0;
        tick(3);
        checkAct("stop edge", ACT_IDLE);
        wr(0, 16'h0004);
        checkAct("stop open", ACT_OPEN);
        @(posedge sys_clk) cfgEsdDisable <= 1'b1;
        hwIn.emergency_shutdown <= 1'b1;
        tick(3);
        checkVec("net disabled", {15'h0, netDisabled}, 16'h0001);
        wr(0, 16'h0002);
        checkAct("disabled close", ACT_OPEN);
        @(posedge sys_clk) hwIn.emergency_shutdown <= 1'b0;
        hwIn.stopClosed <= 1'b1;
        hwIn.maintain <= 1'b1;
        hwIn.close <= 1'b1;
        tick(3);
        @(posedge sys_clk) hwIn.close <= 1'b0;
        tick(3);
        checkAct("maintained", ACT_CLOSE);
        wr(0, 16'h0004);
        checkAct("net over maint", ACT_OPEN);
        // Emergency against the local stop selector
        @(posedge sys_clk) selRemote <= 1'b0;
        selLocalStop <= 1'b1;
        wr(0, 16'h0008);
        checkAct("esd in stop", ACT_IDLE);
        @(posedge sys_clk) cfgEsdOverStop <= 1'b1;
        tick(2);
        checkAct("esd over stop", ACT_ESD);
        wr(0, 16'h0001);
        @(posedge sys_clk) selRemote <= 1'b1;
        selLocalStop <= 1'b0;
        // Partial stroke from the open end, left mid-travel
        @(posedge sys_clk) cfgPstFromOpen <= 1'b1;
        atOpen <= 1'b1;
        wr(0, 16'h0020);
        @(posedge sys_clk) atOpen <= 1'b0;
        tick(2);
        checkAct("pst running", ACT_PST);
        @(posedge sys_clk) pstDone <= 1'b1;
        @(posedge sys_clk) pstDone <= 1'b0;
        tick(1);
        checkAct("pst done", ACT_IDLE);
        // Hard-wired input without the auxiliary mask
        @(posedge sys_clk) hwEnable <= 1'b0;
        hwIn.maintain <= 1'b0;
        hwIn.open <= 1'b1;
        tick(3);
        checkAct("mask off", ACT_IDLE);
        // Relays across a power return in mid-run
        wr(2, 16'h000F);
        checkVec("relays set", {12'h000, relayOut}, 16'h000F);
        @(posedge sys_clk) rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        checkVec("relays power", {12'h000, relayOut}, 16'h0000);
        finishTest();
    end
endmodule

`default_nettype wire
